// file: design/ssb_map.vh
/*
  Constants of the strap, mode and status indicator block: timing, register
  offsets, field positions, reset values and encodings.
  Assumes a 25 MHz core clock and byte addresses on an 8-bit Wishbone address.
*/
`ifndef SSB_MAP_VH
`define SSB_MAP_VH
// timing
`define SSB_CLK_NS          40
`define SSB_BLINK_HALF_MS   500
`define SSB_BLINK_HALF_CYC  (`SSB_BLINK_HALF_MS * 1000000 / `SSB_CLK_NS)
`define SSB_MS_CYC          (1000000 / `SSB_CLK_NS)
`define SSB_RST_MIN_NS      1200
`define SSB_RST_MIN_CYC     ((`SSB_RST_MIN_NS + `SSB_CLK_NS - 1) / `SSB_CLK_NS)
`define SSB_SETTLE_CYC      4'h6
`define SSB_SELFTEST_TGL    2'h2
// capacities
`define SSB_PARAM_MAX       6'h1E
// register byte offsets
`define SSB_ADR_CTRL        8'h00
`define SSB_ADR_STATUS      8'h04
`define SSB_ADR_IRQ_STAT    8'h08
`define SSB_ADR_IRQ_MASK    8'h0C
`define SSB_ADR_PARAM_IDX   8'h10
`define SSB_ADR_PARAM_DATA  8'h14
`define SSB_ADR_IO_IDX      8'h18
`define SSB_ADR_IO_PROD     8'h1C
`define SSB_ADR_IO_CONS     8'h20
`define SSB_ADR_TRIG        8'h24
`define SSB_ADR_CYC_PERIOD  8'h28
// ctrl fields
`define SSB_CTRL_RUN        0
`define SSB_CTRL_FAULT      2:1
// irq bits
`define SSB_IRQ_PARAM       0
`define SSB_IRQ_DPRAM       1
`define SSB_IRQ_CONSUMED    2
`define SSB_IRQ_REFUSED     3
// reset values
`define SSB_IRQ_MASK_RST    4'h0
`define SSB_TRIG_RST        2'h0
`define SSB_PERIOD_RST      16'h0064
// trigger modes
`define SSB_TRIG_POLL       2'h0
`define SSB_TRIG_COS        2'h1
`define SSB_TRIG_CYCLIC     2'h2
// fault levels
`define SSB_FAULT_NONE      2'h0
`define SSB_FAULT_RECOV     2'h1
`define SSB_FAULT_FATAL     2'h2
// lamp patterns
`define SSB_LAMP_OFF        3'h0
`define SSB_LAMP_GRN        3'h1
`define SSB_LAMP_GRN_BLINK  3'h2
`define SSB_LAMP_RED_BLINK  3'h3
`define SSB_LAMP_RED        3'h4
`define SSB_LAMP_ALT        3'h5
`endif

// file: design/ssb_sync.v
/*
  Three-stage input synchroniser with agreement filter.
  Assumes a pin asynchronous to clk; the level follows once stages two and
  three agree.
*/
`timescale 1ns/1ps
`include "ssb_map.vh"
module ssb_sync #(
  parameter RESET_LEVEL = 1'b0
) (
  // clock and reset
  input  wire clk,
  input  wire reset,
  // raw pin and filtered level
  input  wire pin,
  output reg  level
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  // shift chain; first stage feeds only the second
  always @(posedge clk)
  begin
    if (reset)
    begin
      s1_q  <= RESET_LEVEL;
      s2_q  <= RESET_LEVEL;
      s3_q  <= RESET_LEVEL;
      level <= RESET_LEVEL;
    end
    else
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        level <= s3_q;
    end
  end
endmodule

// file: design/ssb_lamp.v
/*
  Two-colour indicator driver with active-low outputs.
  Assumes a pattern code and a blink phase from the same clock domain.
*/
`timescale 1ns/1ps
`include "ssb_map.vh"
module ssb_lamp (
  // clock and reset
  input  wire       clk,
  input  wire       reset,
  // pattern request
  input  wire [2:0] pattern,
  input  wire       phase,
  // indicator pins, low lights
  output reg        green_n,
  output reg        red_n
);
  // pattern to pin levels, unlit in reset
  always @(posedge clk)
  begin
    if (reset)
    begin
      green_n <= 1'b1;
      red_n   <= 1'b1;
    end
    else
    begin
      case (pattern)
        `SSB_LAMP_GRN:       {green_n, red_n} <= {1'b0, 1'b1};
        `SSB_LAMP_GRN_BLINK: {green_n, red_n} <= {~phase, 1'b1};
        `SSB_LAMP_RED_BLINK: {green_n, red_n} <= {1'b1, ~phase};
        `SSB_LAMP_RED:       {green_n, red_n} <= {1'b1, 1'b0};
        `SSB_LAMP_ALT:       {green_n, red_n} <= {~phase, phase};
        default:             {green_n, red_n} <= {1'b1, 1'b1};
      endcase
    end
  end
endmodule

// file: design/ssb_strap_status.v
/*
  Strap sampling, run/config state, host interrupt line direction, parameter
  and I/O data stores, trigger generation and status indicators, with a
  classic Wishbone register slave.
  Assumes one 25 MHz clock, a synchronous active-high reset, straps and the
  host interrupt pin asynchronous, network-side signals on clk.
*/
`timescale 1ns/1ps
`include "ssb_map.vh"
module ssb_strap_status #(
  parameter integer BLINK_HALF_CYC = `SSB_BLINK_HALF_CYC,
  parameter integer MS_CYC         = `SSB_MS_CYC,
  parameter [5:0]   PARAM_DEPTH    = `SSB_PARAM_MAX,
  parameter integer PARAM_W        = 16
) (
  // clock and reset
  input  wire               clk,
  input  wire               reset,
  // wishbone slave
  input  wire [7:0]         wb_adr_i,
  input  wire [31:0]        wb_dat_i,
  input  wire [3:0]         wb_sel_i,
  input  wire               wb_we_i,
  input  wire               wb_cyc_i,
  input  wire               wb_stb_i,
  output reg  [31:0]        wb_dat_o,
  output reg                wb_ack_o,
  // straps
  input  wire               state_select_strap,
  input  wire               host_mode_strap,
  // host interrupt pin
  input  wire               host_int_i,
  output reg                host_int_o,
  output reg                host_int_oe_n,
  // interrupt and mode
  output reg                irq_o,
  output reg                run_state_o,
  output reg                serial_mode_o,
  // indicators
  output wire               module_ok_lamp_n,
  output wire               module_fault_lamp_n,
  output wire               network_ok_lamp_n,
  output wire               network_fault_lamp_n,
  // network side
  input  wire               net_consume_we,
  input  wire [5:0]         net_consume_idx,
  input  wire [7:0]         net_consume_data,
  input  wire               net_consume_done,
  input  wire [5:0]         net_produce_idx,
  output reg  [7:0]         net_produce_data,
  output reg                net_produce_trigger,
  input  wire               net_poll_req,
  input  wire               net_param_access,
  input  wire               net_dup_ok,
  input  wire               net_connected,
  input  wire               net_io_timeout,
  input  wire               net_comm_fault
);
  localparam [1:0]  ST_SETTLE   = 2'h0;
  localparam [1:0]  ST_SELFTEST = 2'h1;
  localparam [1:0]  ST_CONFIG   = 2'h2;
  localparam [1:0]  ST_RUN      = 2'h3;
  localparam [23:0] BLINK_LAST  = BLINK_HALF_CYC[23:0] - 24'h000001;
  localparam [14:0] MS_LAST     = MS_CYC[14:0] - 15'h0001;
  localparam integer RST_MIN_I  = `SSB_RST_MIN_CYC;
  localparam [4:0]  RST_MIN     = RST_MIN_I[4:0];

  // byte-lane merge of a write into a register image
  function [31:0] ssb_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  sel;
    integer      b;
    begin
      ssb_merge = old_v;
      for (b = 0; b < 4; b = b + 1)
        if (sel[b])
          ssb_merge[b*8 +: 8] = new_v[b*8 +: 8];
    end
  endfunction

  reg  [1:0]         state_q;
  reg  [3:0]         settle_q;
  reg  [1:0]         tgl_cnt_q;
  reg  [4:0]         rst_cnt_q;
  reg                short_rst_q;
  reg  [23:0]        blink_cnt_q;
  reg                phase_q;
  reg  [1:0]         fault_q;
  reg  [3:0]         irq_stat_q;
  reg  [3:0]         irq_mask_q;
  reg  [4:0]         param_idx_q;
  reg  [5:0]         param_cnt_q;
  reg  [5:0]         io_idx_q;
  reg  [1:0]         trig_q;
  reg  [15:0]        period_q;
  reg  [14:0]        ms_cnt_q;
  reg  [15:0]        per_cnt_q;
  reg                int_lvl_q;
  reg  [PARAM_W-1:0] param_mem [0:31];
  reg  [7:0]         prod_mem  [0:63];
  reg  [7:0]         cons_mem  [0:63];
  reg  [31:0]        rdata;
  reg  [2:0]         mod_pat;
  reg  [2:0]         net_pat;
  wire [2:0]         pin_raw;
  wire [2:0]         pin_lvl;
  wire               req;
  wire               wr;
  wire               run;
  wire               param_ok;
  wire               blink_wrap;
  wire [31:0]        mrg_ctrl;
  wire [31:0]        mrg_param;
  wire [31:0]        mrg_prod;
  wire [31:0]        mrg_reg;
  wire               st_done;
  wire               cos_write;
  wire               cyc_fire;
  wire               refused;
  wire [3:0]         irq_set;
  wire [3:0]         irq_clr;

  // straps and interrupt pin all pass the synchroniser
  assign pin_raw = {host_int_i, host_mode_strap, state_select_strap};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_sync
      ssb_sync #(
        .RESET_LEVEL (1'b0)
      ) u_sync (
        .clk   (clk),
        .reset (reset),
        .pin   (pin_raw[gi]),
        .level (pin_lvl[gi])
      );
    end
  endgenerate

  // bus request decode; writes land on the acknowledged edge
  assign req       = wb_cyc_i & wb_stb_i;
  assign wr        = req & wb_we_i & wb_ack_o;
  assign run       = (state_q == ST_RUN);
  assign mrg_ctrl  = ssb_merge({29'h0, fault_q, 1'b0}, wb_dat_i, wb_sel_i);
  assign mrg_param = ssb_merge({{(32-PARAM_W){1'b0}}, param_mem[param_idx_q]},
                               wb_dat_i, wb_sel_i);
  assign mrg_prod  = ssb_merge({24'h0, prod_mem[io_idx_q]}, wb_dat_i, wb_sel_i);
  // write merged over the addressed register's current image
  assign mrg_reg   = ssb_merge(rdata, wb_dat_i, wb_sel_i);
  // last edge of self test, pin direction switches with the state
  assign st_done   = (state_q == ST_SELFTEST) && blink_wrap &&
                     (tgl_cnt_q == `SSB_SELFTEST_TGL - 2'h1);
  // config fills below the depth, run touches only stored entries
  assign param_ok  = run ? ({1'b0, param_idx_q} < param_cnt_q)
                         : ((state_q == ST_CONFIG) &&
                            ({1'b0, param_idx_q} < PARAM_DEPTH));
  assign refused   = wr && (((wb_adr_i == `SSB_ADR_PARAM_DATA) && !param_ok) ||
                     ((wb_adr_i == `SSB_ADR_IO_PROD) && !run));
  assign cos_write = wr && run && (wb_adr_i == `SSB_ADR_IO_PROD) &&
                     (mrg_prod[7:0] != prod_mem[io_idx_q]);
  assign blink_wrap = (blink_cnt_q == BLINK_LAST);
  assign cyc_fire  = (ms_cnt_q == MS_LAST) && (period_q != 16'h0000) &&
                     (per_cnt_q + 16'h0001 >= period_q);

  // read mux
  always @*
  begin
    rdata = 32'h0;
    case (wb_adr_i)
      `SSB_ADR_CTRL:       rdata = {29'h0, fault_q, 1'b0};
      `SSB_ADR_STATUS:     rdata = {21'h0, param_cnt_q, short_rst_q, state_q,
                                    serial_mode_o, run_state_o};
      `SSB_ADR_IRQ_STAT:   rdata = {28'h0, irq_stat_q};
      `SSB_ADR_IRQ_MASK:   rdata = {28'h0, irq_mask_q};
      `SSB_ADR_PARAM_IDX:  rdata = {27'h0, param_idx_q};
      `SSB_ADR_PARAM_DATA: rdata = (run && param_ok) ?
                                   {{(32-PARAM_W){1'b0}}, param_mem[param_idx_q]} :
                                   32'h0;
      `SSB_ADR_IO_IDX:     rdata = {26'h0, io_idx_q};
      `SSB_ADR_IO_PROD:    rdata = run ? {24'h0, prod_mem[io_idx_q]} : 32'h0;
      `SSB_ADR_IO_CONS:    rdata = run ? {24'h0, cons_mem[io_idx_q]} : 32'h0;
      `SSB_ADR_TRIG:       rdata = {30'h0, trig_q};
      `SSB_ADR_CYC_PERIOD: rdata = {16'h0, period_q};
      default:             rdata = 32'h0;
    endcase
  end

  // one-wait-state acknowledge, unmapped reads return zero
  always @(posedge clk)
  begin
    if (reset)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= req & ~wb_ack_o;
      if (req & ~wb_ack_o)
        wb_dat_o <= rdata;
    end
  end

  // reset length watch; pulses under the minimum are flagged
  always @(posedge clk)
  begin
    if (reset)
    begin
      // an unknown or stray count restarts, a full count stays
      if (rst_cnt_q == RST_MIN)
        rst_cnt_q <= RST_MIN;
      else if (rst_cnt_q < RST_MIN)
        rst_cnt_q <= rst_cnt_q + 5'h01;
      else
        rst_cnt_q <= 5'h01;
    end
    else if (state_q != ST_SETTLE)
      rst_cnt_q <= 5'h00;
  end

  // start-up sequence and run/config state
  always @(posedge clk)
  begin
    if (reset)
    begin
      state_q       <= ST_SETTLE;
      settle_q      <= 4'h0;
      tgl_cnt_q     <= 2'h0;
      short_rst_q   <= 1'b0;
      run_state_o   <= 1'b0;
      serial_mode_o <= 1'b1;
    end
    else
    begin
      case (state_q)
        ST_SETTLE:
        begin
          settle_q <= settle_q + 4'h1;
          if (settle_q == 4'h0)
            short_rst_q <= (rst_cnt_q < RST_MIN);
          if (settle_q == `SSB_SETTLE_CYC)
          begin
            serial_mode_o <= pin_lvl[1];
            run_state_o   <= 1'b0;
            state_q       <= ST_SELFTEST;
          end
        end
        ST_SELFTEST:
        begin
          if (blink_wrap)
            tgl_cnt_q <= tgl_cnt_q + 2'h1;
          if (st_done)
          begin
            // strap value taken once, later changes ignored
            if (pin_lvl[0])
            begin
              state_q     <= ST_RUN;
              run_state_o <= 1'b1;
            end
            else
              state_q <= ST_CONFIG;
          end
        end
        ST_CONFIG:
        begin
          if (wr && (wb_adr_i == `SSB_ADR_CTRL) && wb_sel_i[0] &&
              wb_dat_i[`SSB_CTRL_RUN])
          begin
            state_q     <= ST_RUN;
            run_state_o <= 1'b1;
          end
        end
        ST_RUN:
          state_q <= ST_RUN;
        default:
          state_q <= ST_SETTLE;
      endcase
    end
  end

  // blink timebase, half period 500 ms
  always @(posedge clk)
  begin
    if (reset)
    begin
      blink_cnt_q <= 24'h000000;
      phase_q     <= 1'b0;
    end
    else if (blink_wrap)
    begin
      blink_cnt_q <= 24'h000000;
      phase_q     <= ~phase_q;
    end
    else
      blink_cnt_q <= blink_cnt_q + 24'h000001;
  end

  // software control registers
  always @(posedge clk)
  begin
    if (reset)
    begin
      fault_q     <= `SSB_FAULT_NONE;
      irq_mask_q  <= `SSB_IRQ_MASK_RST;
      param_idx_q <= 5'h00;
      io_idx_q    <= 6'h00;
      trig_q      <= `SSB_TRIG_RST;
      period_q    <= `SSB_PERIOD_RST;
    end
    else if (wr)
    begin
      case (wb_adr_i)
        `SSB_ADR_CTRL:       fault_q     <= mrg_ctrl[`SSB_CTRL_FAULT];
        `SSB_ADR_IRQ_MASK:   irq_mask_q  <= mrg_reg[3:0];
        `SSB_ADR_PARAM_IDX:  param_idx_q <= mrg_reg[4:0];
        `SSB_ADR_IO_IDX:     io_idx_q    <= mrg_reg[5:0];
        `SSB_ADR_TRIG:       trig_q      <= mrg_reg[1:0];
        `SSB_ADR_CYC_PERIOD: period_q    <= mrg_reg[15:0];
        default:             fault_q     <= fault_q;
      endcase
    end
  end

  // parameter store: descriptions in config, values in run
  always @(posedge clk)
  begin
    if (reset)
      param_cnt_q <= 6'h00;
    else if (wr && (wb_adr_i == `SSB_ADR_PARAM_DATA) && param_ok)
    begin
      param_mem[param_idx_q] <= mrg_param[PARAM_W-1:0];
      if (!run && ({1'b0, param_idx_q} >= param_cnt_q))
        param_cnt_q <= {1'b0, param_idx_q} + 6'h01;
    end
  end

  // 64-byte produced and consumed blocks
  always @(posedge clk)
  begin
    if (wr && run && (wb_adr_i == `SSB_ADR_IO_PROD))
      prod_mem[io_idx_q] <= mrg_prod[7:0];
    if (run && net_consume_we)
      cons_mem[net_consume_idx] <= net_consume_data;
    net_produce_data <= prod_mem[net_produce_idx];
  end

  // produced data trigger: polled, change of state or cyclic
  always @(posedge clk)
  begin
    if (reset)
    begin
      ms_cnt_q            <= 15'h0000;
      per_cnt_q           <= 16'h0000;
      net_produce_trigger <= 1'b0;
    end
    else
    begin
      ms_cnt_q <= (ms_cnt_q == MS_LAST) ? 15'h0000 : ms_cnt_q + 15'h0001;
      if (cyc_fire || trig_q != `SSB_TRIG_CYCLIC)
        per_cnt_q <= 16'h0000;
      else if (ms_cnt_q == MS_LAST)
        per_cnt_q <= per_cnt_q + 16'h0001;
      case (trig_q)
        `SSB_TRIG_POLL:   net_produce_trigger <= run & net_poll_req;
        `SSB_TRIG_COS:    net_produce_trigger <= cos_write;
        `SSB_TRIG_CYCLIC: net_produce_trigger <= run & cyc_fire;
        default:          net_produce_trigger <= 1'b0;
      endcase
    end
  end

  // sticky events, write one to clear, set wins over clear
  assign irq_set[`SSB_IRQ_PARAM]    = net_param_access;
  assign irq_set[`SSB_IRQ_DPRAM]    = !serial_mode_o && (state_q[1]) &&
                                      pin_lvl[2] && !int_lvl_q;
  assign irq_set[`SSB_IRQ_CONSUMED] = run & net_consume_done;
  assign irq_set[`SSB_IRQ_REFUSED]  = refused;
  assign irq_clr = (wr && (wb_adr_i == `SSB_ADR_IRQ_STAT) && wb_sel_i[0]) ?
                   wb_dat_i[3:0] : 4'h0;

  always @(posedge clk)
  begin
    if (reset)
    begin
      irq_stat_q <= 4'h0;
      int_lvl_q  <= 1'b0;
      irq_o      <= 1'b0;
    end
    else
    begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      int_lvl_q  <= pin_lvl[2];
      irq_o      <= |(irq_stat_q & irq_mask_q);
    end
  end

  // interrupt pin direction follows the latched host mode
  always @(posedge clk)
  begin
    if (reset)
    begin
      host_int_o    <= 1'b0;
      host_int_oe_n <= 1'b1;
    end
    else if ((state_q[1] || st_done) && serial_mode_o)
    begin
      host_int_o    <= irq_stat_q[`SSB_IRQ_PARAM];
      host_int_oe_n <= 1'b0;
    end
    else
    begin
      host_int_o    <= 1'b0;
      host_int_oe_n <= 1'b1;
    end
  end

  // lamp pattern selection
  always @*
  begin
    if (!state_q[1])
      mod_pat = `SSB_LAMP_ALT;
    else if (fault_q == `SSB_FAULT_FATAL)
      mod_pat = `SSB_LAMP_RED;
    else if (fault_q == `SSB_FAULT_RECOV)
      mod_pat = `SSB_LAMP_RED_BLINK;
    else if (run)
      mod_pat = `SSB_LAMP_GRN;
    else
      mod_pat = `SSB_LAMP_GRN_BLINK;
    if (net_comm_fault)
      net_pat = `SSB_LAMP_RED;
    else if (!net_dup_ok)
      net_pat = `SSB_LAMP_OFF;
    else if (net_io_timeout)
      net_pat = `SSB_LAMP_RED_BLINK;
    else if (net_connected)
      net_pat = `SSB_LAMP_GRN;
    else
      net_pat = `SSB_LAMP_GRN_BLINK;
  end

  // indicator drivers, active low
  ssb_lamp u_mod_lamp (
    .clk     (clk),
    .reset   (reset),
    .pattern (mod_pat),
    .phase   (phase_q),
    .green_n (module_ok_lamp_n),
    .red_n   (module_fault_lamp_n)
  );

  ssb_lamp u_net_lamp (
    .clk     (clk),
    .reset   (reset),
    .pattern (net_pat),
    .phase   (phase_q),
    .green_n (network_ok_lamp_n),
    .red_n   (network_fault_lamp_n)
  );
endmodule

// file: bench/ssb_chk.sv
/* checker of the strap and status block
   assumes the top module's ports, bound at the foot */
`timescale 1ns/1ps
module ssb_chk (
  // clock and reset
  input logic clk,
  input logic reset,
  // bus handshake
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_ack_o,
  // pin, mode, trigger, network levels
  input logic host_int_o,
  input logic host_int_oe_n,
  input logic irq_o,
  input logic run_state_o,
  input logic serial_mode_o,
  input logic net_produce_trigger,
  input logic net_dup_ok,
  input logic net_comm_fault,
  // indicators
  input logic module_ok_lamp_n,
  input logic module_fault_lamp_n,
  input logic network_ok_lamp_n,
  input logic network_fault_lamp_n
);
  // one clock domain
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // reset values
  a_reset_dark: assert property (disable iff (1'b0)
    reset |=> module_ok_lamp_n && module_fault_lamp_n && network_ok_lamp_n
    && network_fault_lamp_n && !host_int_o) else $error("lamp lit in reset");
  a_reset_idle: assert property (disable iff (1'b0)
    reset |=> !irq_o && !run_state_o && host_int_oe_n) else $error("busy in reset");
  // bus answer after one wait, for one cycle
  a_ack_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  // pin direction, latched mode, state
  a_pin_dir: assert property (run_state_o |-> host_int_oe_n == !serial_mode_o)
    else $error("pin direction");
  a_mode_held: assert property (run_state_o |=> $stable(serial_mode_o))
    else $error("mode moved");
  a_run_kept: assert property (run_state_o |=> run_state_o)
    else $error("run left");
  a_trig_run: assert property (net_produce_trigger |-> run_state_o)
    else $error("trigger outside run");
  // indicator relations
  a_lamp_excl: assert property (!module_ok_lamp_n |-> module_fault_lamp_n)
    else $error("module lamps both lit");
  a_net_off: assert property ((!net_dup_ok && !net_comm_fault) [*3] |->
    network_ok_lamp_n && network_fault_lamp_n) else $error("network lamp lit");
  a_net_dead: assert property (net_comm_fault [*3] |->
    !network_fault_lamp_n && network_ok_lamp_n) else $error("network not red");
  // main scenarios
  c_run: cover property ($rose(run_state_o));
  c_irq: cover property (irq_o);
  c_trig: cover property (net_produce_trigger);
  c_pin: cover property (!host_int_oe_n && host_int_o);
endmodule
bind ssb_strap_status ssb_chk u_chk (.*);

// file: bench/ssb_host.sv
/* host side of the interrupt pin
   assumes the device's split pin signals on one clock */
`timescale 1ns/1ps
module ssb_host (
  // clock
  input  logic clk,
  // device side of the pin
  input  logic host_int_o,
  input  logic host_int_oe_n,
  // memory irq request
  input  logic raise,
  // resolved pin level
  output logic host_int_i
);
  logic drv_q;
  // memory irq launched after an edge
  always @(posedge clk)
    drv_q <= raise;
  // device drives while its enable is low
  assign host_int_i = host_int_oe_n ? drv_q : host_int_o;
endmodule

// file: bench/test_ssb_strap_status.sv
/* self-checking bench of ssb_strap_status
   assumes short blink and ms counts set below */
`timescale 1ns/1ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin fail_count++; \
  $display("ERROR %s expected %0h seen %0h", n, e, a); end end
module test_ssb_strap_status;
  // design pins
  logic        clk, reset, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, raise;
  logic        state_select_strap, host_mode_strap, host_int_i, host_int_o;
  logic        host_int_oe_n, irq_o, run_state_o, serial_mode_o, net_produce_trigger;
  logic [3:0]  wb_sel_i, pls, nl;
  logic [5:0]  net_consume_idx, net_produce_idx;
  logic [7:0]  wb_adr_i, net_consume_data, net_produce_data;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  wire         module_ok_lamp_n, module_fault_lamp_n, network_ok_lamp_n, network_fault_lamp_n;
  wire         net_consume_we, net_consume_done, net_poll_req, net_param_access;
  wire         net_dup_ok, net_connected, net_io_timeout, net_comm_fault;
  wire [3:0]   lp = {module_ok_lamp_n, module_fault_lamp_n, network_ok_lamp_n,
                     network_fault_lamp_n};
  // model state
  int          fail_count, comparisons, seed, n;
  int          pq[$];
  logic [7:0]  cm[64], qm[64];
  logic [15:0] tab[5] = '{16'h0C05, 16'h0825, 16'h2A5A, 16'h490A, 16'h0007};
  // network pulses and levels
  assign {net_consume_we, net_consume_done, net_poll_req, net_param_access} = pls;
  assign {net_dup_ok, net_connected, net_io_timeout, net_comm_fault} = nl;
  ssb_strap_status #(.BLINK_HALF_CYC(8), .MS_CYC(4)) DUT (.*);
  ssb_host u_host (.*);
  // clock
  initial
  begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  // one classic bus cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, w, a, d, 4'hF};
    k = 0;
    do @(posedge clk); while (wb_ack_o !== 1'b1 && ++k < 50);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(0, a, 0);
    `CHK(nm, e, rd)
  endtask
  task automatic pulse(input logic [3:0] p);
    @(posedge clk) pls <= p;
    @(posedge clk) pls <= 0;
  endtask
  // toggles of each lamp over two half periods
  task automatic lamps(input logic [3:0] bl, input logic [3:0] lv);
    logic [3:0] p;
    int t[4];
    repeat (4) @(negedge clk);
    p = lp;
    t = '{0, 0, 0, 0};
    repeat (16)
    begin
      @(negedge clk);
      for (int i = 0; i < 4; i++) t[i] += (lp[i] !== p[i]);
      p = lp;
    end
    for (int i = 0; i < 4; i++)
      if (bl[i]) `CHK("blink", 2, t[i])
      else `CHK("lamp", {1'b1, lv[i]}, {t[i] == 0, lp[i]})
  endtask
  task automatic trig(input int c, input int e);
    n = 0;
    repeat (c) @(negedge clk) n += net_produce_trigger;
    `CHK("trigger", e, n)
  endtask
  task automatic wait_state(input logic [1:0] s);
    int k;
    k = 0;
    do wb(0, 8'h04, 0); while (rd[3:2] !== s && ++k < 60);
  endtask
  task automatic close_out;
    if (fail_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // watchdog
  initial
  begin
    repeat (30000) @(posedge clk);
    fail_count++;
    close_out;
  end
  // main sequence
  initial
  begin
    {reset, wb_cyc_i, wb_stb_i, wb_we_i, raise, wb_adr_i, wb_dat_i, wb_sel_i} = 1'b1 << 48;
    {pls, nl, net_consume_idx, net_produce_idx, net_consume_data} = 0;
    {state_select_strap, host_mode_strap, seed} = {2'h1, 32'had953132};
    {fail_count, comparisons} = 0;
    // short reset, configuration, serial host
    repeat (3) @(posedge clk);
    reset <= 0;
    wait_state(2'h2);
    `CHK("status", 32'h1A, rd)
    `CHK("pin oe", 1'b0, host_int_oe_n)
    lamps(4'h8, 4'h7);
    for (int i = 0; i < 31; i++)
    begin
      n = $random(seed) & 16'hFFFF;
      if (i < 30) pq.push_back(n);
      wb(1, 8'h10, i);
      wb(1, 8'h14, n);
    end
    rdc(8'h04, 32'h3DA, "count");
    rdc(8'h08, 32'h8, "refused");
    rdc(8'h14, 0, "cfg read");
    rdc(8'h3C, 0, "unmapped");
    wb(1, 8'h08, 32'hF);
    wb(1, 8'h00, 1);
    rdc(8'h04, 32'h3DF, "run");
    foreach (pq[i])
    begin
      wb(1, 8'h10, i);
      rdc(8'h14, pq[i], "param");
    end
    // consumed and produced bytes
    for (int i = 0; i < 64; i++)
    begin
      cm[i] = 8'($random(seed));
      qm[i] = 8'($random(seed));
      {net_consume_idx, net_consume_data} <= {6'(i), cm[i]};
      pulse(4'h8);
      wb(1, 8'h18, i);
      wb(1, 8'h1C, qm[i]);
    end
    pulse(4'h4);
    for (int i = 0; i < 64; i++)
    begin
      wb(1, 8'h18, i);
      rdc(8'h20, cm[i], "consumed");
      @(posedge clk) net_produce_idx <= i;
      repeat (2) @(negedge clk);
      `CHK("produced", qm[i], net_produce_data)
    end
    rdc(8'h08, 32'h4, "done");
    // polled, change of state, cyclic
    pulse(4'h2);
    trig(4, 1);
    wb(1, 8'h24, 1);
    wb(1, 8'h1C, ~qm[63]);
    trig(4, 1);
    wb(1, 8'h28, 1);
    wb(1, 8'h24, 2);
    trig(16, 4);
    wb(1, 8'h24, 0);
    // parameter access flag, cleared, then masked
    wb(1, 8'h08, 32'hF);
    wb(1, 8'h0C, 1);
    pulse(4'h1);
    repeat (3) @(negedge clk);
    `CHK("irq", 2'h3, {irq_o, host_int_i})
    wb(1, 8'h08, 1);
    wb(1, 8'h0C, 0);
    pulse(4'h1);
    repeat (3) @(negedge clk);
    `CHK("masked", 2'h1, {irq_o, host_int_i})
    @(posedge clk) {state_select_strap, host_mode_strap} <= 2'h2;
    repeat (12) @(negedge clk);
    `CHK("held", 2'h3, {serial_mode_o, run_state_o})
    // long reset, working state, parallel host
    @(posedge clk) reset <= 1;
    repeat (30) @(negedge clk);
    `CHK("dark", 5'h1F, {lp, host_int_oe_n})
    @(posedge clk) reset <= 0;
    wait_state(2'h3);
    `CHK("status", 32'hD, rd)
    `CHK("pin oe", 1'b1, host_int_oe_n)
    @(posedge clk) raise <= 1;
    repeat (8) @(posedge clk);
    raise <= 0;
    rdc(8'h08, 2, "memory irq");
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk) nl <= tab[i][11:8];
      wb(1, 8'h00, tab[i][15:12]);
      lamps(tab[i][7:4], tab[i][3:0]);
    end
    close_out;
  end
endmodule
